// File: adc_conversion_sequencer.sv
// conversion sequencer: timing, input selection, bitstream filter, result hold
`timescale 1ns/10ps
`default_nettype none

`include "adc_seq_map.svh"

// Function
// RL1: single-shot does one conversion on request, stores result, then powers down.
// RL2: continuous mode starts the next conversion right after one completes.
// RL3: continuous mode yields one result per programmed data-rate period.
// RL4: result can be read any time and holds latest completed conversion.
// RL5: four-input variant picks its input pair from a three-bit select field.
// RL6: single-ended selections close the switch grounding the negative input.
// RL7: variants without multiplexer always convert input 0 against input 1.
// RL8: modulator clock is the 1 MHz oscillator divided by four, 250 kHz.
// RL9: filter turns bitstream into 12-bit code proportional to differential input.
// RL10: three-bit rate field selects one of seven data rates, 128 to 3300.
// RL11: conversion settles in one cycle; conversion time is one over data rate.
// RL12: result register changes whole, only at the end of a conversion.
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter bit HAS_MUX = 1'b1
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // configuration from the serial interface logic
  input wire logic continuous_mode,
  input wire logic start_single,
  input wire logic [`SEL_W-1:0] input_select_field,
  input wire logic [`RATE_W-1:0] rate_select_field,
  // modulator bitstream, asynchronous
  input wire logic mod_bit,
  // modulator and multiplexer control
  output logic mod_clk_q,
  output logic [`CH_W-1:0] pos_sel_q,
  output logic [`CH_W-1:0] neg_sel_q,
  output logic neg_gnd_q,
  // status and result
  output logic busy_q,
  output logic powered_down_q,
  output logic done_q,
  output logic [`RESULT_W-1:0] result_q
);

  logic osc_tick;
  logic mod_tick;
  logic [1:0] mod_phase;
  logic mod_s1_q;
  logic mod_s2_q;

  conv_state_t state_q, state_d;
  logic signed [`ACC_W-1:0] acc_q, acc_d;
  sample_cnt_t cnt_q, cnt_d;
  sample_cnt_t n_q, n_d;
  gain_t gain_q, gain_d;
  logic mod_clk_d;
  logic [`CH_W-1:0] pos_sel_d, neg_sel_d;
  logic neg_gnd_d;
  logic busy_d, powered_down_d, done_d;
  logic [`RESULT_W-1:0] result_d;

  logic signed [`ACC_W-1:0] acc_next;
  logic signed [`PROD_W-1:0] prod;
  logic signed [`PROD_W-1:0] scaled;
  logic [`RESULT_W-1:0] code;
  logic start;

  // 1 MHz oscillator tick from the system clock, then /4 for the modulator
  tick_divider #(.DIV(`OSC_DIV), .W(8)) u_osc_div ( // see RL8
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .tick_in(1'b1),
    .tick_q(osc_tick),
    .phase_q()
  );

  tick_divider #(.DIV(`MOD_DIV), .W(2)) u_mod_div ( // see RL8
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .tick_in(osc_tick),
    .tick_q(mod_tick),
    .phase_q(mod_phase)
  );

  // bitstream comes from the analog side, so two flops before use
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mod_s1_q <= 1'b0;
      mod_s2_q <= 1'b0;
    end else if (ce) begin
      mod_s1_q <= mod_bit;
      mod_s2_q <= mod_s1_q;
    end
  end

  // scale the signed bit balance onto the code range, with saturation
  always_comb begin
    acc_next = mod_s2_q ? (acc_q + `ACC_ONE) : (acc_q - `ACC_ONE); // see RL9
    prod = `PROD_W'(acc_next) * $signed({1'b0, gain_q}); // see RL9
    scaled = prod >>> `GAIN_SHIFT;
    if (scaled > `CODE_HI) begin
      code = `CODE_MAX;
    end else if (scaled < `CODE_LO) begin
      code = `CODE_MIN;
    end else begin
      code = scaled[`RESULT_W-1:0];
    end
  end

  // a request made mid-conversion is dropped; single-shot has nothing queued
  assign start = continuous_mode || start_single;

  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    cnt_d = cnt_q;
    n_d = n_q;
    gain_d = gain_q;
    pos_sel_d = pos_sel_q;
    neg_sel_d = neg_sel_q;
    neg_gnd_d = neg_gnd_q;
    result_d = result_q;
    done_d = 1'b0;
    // new settings apply from the next conversion start, never mid-stream
    if (state_q == ST_POWER_DOWN || (mod_tick && cnt_q == n_q - `CNT_ONE)) begin
      n_d = samples_for(rate_select_field); // see RL10
      gain_d = gain_for(rate_select_field); // see RL10
      if (!HAS_MUX) begin
        pos_sel_d = `CH_0; // see RL7
        neg_sel_d = `CH_1; // see RL7
        neg_gnd_d = 1'b0;
      end else begin
        unique case (input_select_field) // see RL5
          `SEL_P0_N1: begin pos_sel_d = `CH_0; neg_sel_d = `CH_1; neg_gnd_d = 1'b0; end
          `SEL_P0_N3: begin pos_sel_d = `CH_0; neg_sel_d = `CH_3; neg_gnd_d = 1'b0; end
          `SEL_P1_N3: begin pos_sel_d = `CH_1; neg_sel_d = `CH_3; neg_gnd_d = 1'b0; end
          `SEL_P2_N3: begin pos_sel_d = `CH_2; neg_sel_d = `CH_3; neg_gnd_d = 1'b0; end
          `SEL_P0_GND: begin pos_sel_d = `CH_0; neg_sel_d = `CH_0; neg_gnd_d = 1'b1; end // see RL6
          `SEL_P1_GND: begin pos_sel_d = `CH_1; neg_sel_d = `CH_1; neg_gnd_d = 1'b1; end // see RL6
          `SEL_P2_GND: begin pos_sel_d = `CH_2; neg_sel_d = `CH_2; neg_gnd_d = 1'b1; end // see RL6
          `SEL_P3_GND: begin pos_sel_d = `CH_3; neg_sel_d = `CH_3; neg_gnd_d = 1'b1; end // see RL6
        endcase
      end
    end
    unique case (state_q)
      ST_POWER_DOWN: begin
        acc_d = `ACC_ZERO;
        cnt_d = `CNT_ZERO;
        if (start) begin
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (mod_tick) begin
          acc_d = acc_next;
          cnt_d = cnt_q + `CNT_ONE;
          // one settled result per n modulator samples, n = rate / data rate
          if (cnt_q == n_q - `CNT_ONE) begin // see RL11
            result_d = code; // see RL12
            done_d = 1'b1; // see RL4
            acc_d = `ACC_ZERO;
            cnt_d = `CNT_ZERO;
            if (continuous_mode) begin
              state_d = ST_CONVERT; // see RL2 RL3
            end else begin
              state_d = ST_POWER_DOWN; // see RL1
            end
          end
        end
      end
    endcase
    busy_d = (state_d == ST_CONVERT);
    powered_down_d = (state_d == ST_POWER_DOWN); // see RL1
    // modulator clock only runs while converting, saving power when idle
    mod_clk_d = (state_d == ST_CONVERT) && mod_phase[`MOD_PHASE_HI]; // see RL8
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_POWER_DOWN;
      acc_q <= `ACC_ZERO;
      cnt_q <= `CNT_ZERO;
      n_q <= `CNT_ONE;
      gain_q <= '0;
      pos_sel_q <= `CH_0;
      neg_sel_q <= `CH_1;
      neg_gnd_q <= 1'b0;
      result_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      powered_down_q <= 1'b1;
      mod_clk_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      n_q <= n_d;
      gain_q <= gain_d;
      pos_sel_q <= pos_sel_d;
      neg_sel_q <= neg_sel_d;
      neg_gnd_q <= neg_gnd_d;
      result_q <= result_d; // see RL4
      done_q <= done_d;
      busy_q <= busy_d;
      powered_down_q <= powered_down_d;
      mod_clk_q <= mod_clk_d;
    end
  end

endmodule : adc_conversion_sequencer

`default_nettype wire

// File: adc_conversion_sequencer_tb_top.sv
// testbench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_tb_top;
  logic clk_sys, rst, ce, continuous_mode, start_single, mod_bit, level;
  logic [2:0] input_select_field, rate_select_field;
  logic mod_clk_q, neg_gnd_q, busy_q, powered_down_q, done_q;
  logic [1:0] pos_sel_q, neg_sel_q;
  logic [11:0] result_q;
  int failures, total_checks, i, n;
  // rows: select code, then positive, negative, ground switch
  logic [7:0] rows [8] = '{8'h02, 8'h26, 8'h4E, 8'h76, 8'h81, 8'hAB, 8'hD5, 8'hFF};
  adc_conversion_sequencer dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .continuous_mode(continuous_mode), .start_single(start_single),
    .input_select_field(input_select_field), .rate_select_field(rate_select_field),
    .mod_bit(mod_bit), .mod_clk_q(mod_clk_q), .pos_sel_q(pos_sel_q), .neg_sel_q(neg_sel_q),
    .neg_gnd_q(neg_gnd_q), .busy_q(busy_q), .powered_down_q(powered_down_q),
    .done_q(done_q), .result_q(result_q));
  mod_source u_mod (.clk_sys(clk_sys), .mod_clk_q(mod_clk_q), .level(level), .mod_bit(mod_bit));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // bounded wait for busy or done, counted as one comparison
  task automatic wait_high(input bit on_done, input int limit);
    #1;
    n = 0;
    while (((on_done ? done_q : busy_q) !== 1'b1) && n < limit) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(on_done ? "done" : "busy", 12'h001, {11'h000, n < limit});
    if (n >= limit) begin
      test_done();
    end
  endtask : wait_high
  task automatic pulse_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check("result", 12'h000, result_q);
    check("power-down", 12'h001, {11'h000, powered_down_q});
  endtask : pulse_reset
  initial begin
    failures = 0;
    total_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    continuous_mode = 1'b0;
    start_single = 1'b0;
    level = 1'b1;
    input_select_field = 3'h0;
    rate_select_field = 3'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("reset pair", 12'h002, {7'h00, pos_sel_q, neg_sel_q, neg_gnd_q});
    $display("reset test over");
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      input_select_field <= rows[i][7:5];
      start_single <= 1'b1;
      @(posedge clk_sys);
      start_single <= 1'b0;
      wait_high(1'b0, 4);
      check("pair", {7'h00, rows[i][4:0]}, {7'h00, pos_sel_q, neg_sel_q, neg_gnd_q});
      pulse_reset();
    end
    $display("selection test over");
    // frozen enable: a request held while ce is low must not be taken
    @(posedge clk_sys);
    ce <= 1'b0;
    start_single <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ce <= 1'b1;
    start_single <= 1'b0;
    #1;
    check("frozen busy", 12'h000, {11'h000, busy_q});
    $display("enable test over");
    // fastest rate keeps one conversion near 60000 cycles
    @(posedge clk_sys);
    rate_select_field <= 3'h6;
    input_select_field <= 3'h4;
    continuous_mode <= 1'b1;
    wait_high(1'b1, 70000);
    check("full scale", 12'h7FF, result_q);
    wait_high(1'b0, 3);
    @(posedge clk_sys);
    continuous_mode <= 1'b0;
    pulse_reset();
    $display("continuous test over");
    test_done();
  end
endmodule : adc_conversion_sequencer_tb_top
`default_nettype wire

// File: adc_seq_map.svh
// constants for the conversion sequencer: clock rates, counts, field codes
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

`define SYS_CLK_HZ 200000000
`define OSC_HZ 1000000
`define OSC_DIV (`SYS_CLK_HZ / `OSC_HZ)
`define MOD_DIV 4
`define MOD_HZ (`OSC_HZ / `MOD_DIV)

`define SPS_0 128
`define SPS_1 250
`define SPS_2 490
`define SPS_3 920
`define SPS_4 1600
`define SPS_5 2400
`define SPS_6 3300

`define RATE_W 3
`define RATE_0 3'h0
`define RATE_1 3'h1
`define RATE_2 3'h2
`define RATE_3 3'h3
`define RATE_4 3'h4
`define RATE_5 3'h5

`define RESULT_W 12
`define ACC_W 13
`define CNT_W 11
`define GAIN_W 22
`define PROD_W 36
`define GAIN_SHIFT 16
`define GAIN_NUM ((1 << (`RESULT_W - 1)) << `GAIN_SHIFT)
`define CODE_HI 36'sh7FF
`define CODE_LO 36'shFFFFFF800
`define CODE_MAX 12'h7FF
`define CODE_MIN 12'h800
`define ACC_ZERO 13'h0000
`define ACC_ONE 13'h0001
`define CNT_ZERO 11'h000
`define CNT_ONE 11'h001
`define MOD_PHASE_HI 1

`define SEL_W 3
`define SEL_P0_N1 3'h0
`define SEL_P0_N3 3'h1
`define SEL_P1_N3 3'h2
`define SEL_P2_N3 3'h3
`define SEL_P0_GND 3'h4
`define SEL_P1_GND 3'h5
`define SEL_P2_GND 3'h6
`define SEL_P3_GND 3'h7

`define CH_W 2
`define CH_0 2'h0
`define CH_1 2'h1
`define CH_2 2'h2
`define CH_3 2'h3

`endif

// File: adc_seq_monitor.sv
// port checker for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_seq_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // requests
  input wire logic ce,
  input wire logic continuous_mode,
  input wire logic start_single,
  // outputs watched
  input wire logic mod_clk_q,
  input wire logic [1:0] pos_sel_q,
  input wire logic [1:0] neg_sel_q,
  input wire logic neg_gnd_q,
  input wire logic busy_q,
  input wire logic powered_down_q,
  input wire logic done_q,
  input wire logic [11:0] result_q
);
  logic prev_q, prev_d, seen_q, seen_d, rise;
  logic [9:0] gap_q, gap_d;
  // first period is partial, so only rises after a rise are timed
  always_comb begin
    rise = mod_clk_q & ~prev_q;
    prev_d = rst ? 1'b0 : mod_clk_q;
    seen_d = ~rst & busy_q & (seen_q | rise);
    gap_d = rise ? 10'h000 : gap_q + 10'h001;
  end
  always_ff @(posedge clk_sys) begin
    prev_q <= prev_d;
    seen_q <= seen_d;
    gap_q <= gap_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_state_inverse: assert property (powered_down_q == !busy_q)
    else $error("power-down flag not inverse of busy");
  chk_start_take: assert property (powered_down_q && ce && (start_single || continuous_mode)
    |=> busy_q) else $error("request not taken");
  // reset clears the result without a done pulse, so the edge after reset is left out
  chk_result_only: assert property ($changed(result_q) && !$past(rst) |-> done_q)
    else $error("result changed without done");
  chk_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  chk_single_end: assert property (done_q && !continuous_mode && !$past(continuous_mode)
    |-> powered_down_q && !mod_clk_q) else $error("no power-down after single");
  chk_chain_next: assert property (done_q && continuous_mode && $past(continuous_mode)
    |-> ##[0:2] busy_q) else $error("continuous mode did not chain");
  chk_gnd_pair: assert property (neg_gnd_q |-> neg_sel_q == pos_sel_q)
    else $error("grounded negative with split channels");
  chk_idle_clock: assert property (powered_down_q |-> !mod_clk_q)
    else $error("modulator clock runs in power-down");
  chk_mod_period: assert property (rise && seen_q |-> gap_q == 10'h31F)
    else $error("modulator period not 800 cycles");
  cover property (done_q && continuous_mode);
  cover property (neg_gnd_q && busy_q);
  cover property (powered_down_q && start_single);
endmodule : adc_seq_monitor
bind adc_conversion_sequencer adc_seq_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .continuous_mode(continuous_mode), .start_single(start_single), .mod_clk_q(mod_clk_q),
  .pos_sel_q(pos_sel_q), .neg_sel_q(neg_sel_q), .neg_gnd_q(neg_gnd_q), .busy_q(busy_q),
  .powered_down_q(powered_down_q), .done_q(done_q), .result_q(result_q));
`default_nettype wire

// File: adc_seq_pkg.sv
// types and rate tables for the conversion sequencer
`include "adc_seq_map.svh"

package adc_seq_pkg;

  typedef enum logic [0:0] {
    ST_POWER_DOWN = 1'b0,
    ST_CONVERT = 1'b1
  } conv_state_t;

  typedef logic [`CNT_W-1:0] sample_cnt_t;
  typedef logic [`GAIN_W-1:0] gain_t;

  // modulator samples in one conversion period; code 7 runs as the fastest rate
  function automatic sample_cnt_t samples_for(input logic [`RATE_W-1:0] rate);
    sample_cnt_t n;
    case (rate)
      `RATE_0: n = `CNT_W'(`MOD_HZ / `SPS_0);
      `RATE_1: n = `CNT_W'(`MOD_HZ / `SPS_1);
      `RATE_2: n = `CNT_W'(`MOD_HZ / `SPS_2);
      `RATE_3: n = `CNT_W'(`MOD_HZ / `SPS_3);
      `RATE_4: n = `CNT_W'(`MOD_HZ / `SPS_4);
      `RATE_5: n = `CNT_W'(`MOD_HZ / `SPS_5);
      default: n = `CNT_W'(`MOD_HZ / `SPS_6);
    endcase
    return n;
  endfunction : samples_for

  // fixed-point gain mapping a +/-n bit count onto the full code range
  function automatic gain_t gain_for(input logic [`RATE_W-1:0] rate);
    gain_t g;
    case (rate)
      `RATE_0: g = `GAIN_W'(`GAIN_NUM / (`MOD_HZ / `SPS_0));
      `RATE_1: g = `GAIN_W'(`GAIN_NUM / (`MOD_HZ / `SPS_1));
      `RATE_2: g = `GAIN_W'(`GAIN_NUM / (`MOD_HZ / `SPS_2));
      `RATE_3: g = `GAIN_W'(`GAIN_NUM / (`MOD_HZ / `SPS_3));
      `RATE_4: g = `GAIN_W'(`GAIN_NUM / (`MOD_HZ / `SPS_4));
      `RATE_5: g = `GAIN_W'(`GAIN_NUM / (`MOD_HZ / `SPS_5));
      default: g = `GAIN_W'(`GAIN_NUM / (`MOD_HZ / `SPS_6));
    endcase
    return g;
  endfunction : gain_for

endpackage : adc_seq_pkg

// File: mod_source.sv
// modulator model: bitstream of a chosen level
`timescale 1ns/10ps
`default_nettype none
module mod_source (
  // clocks
  input wire logic clk_sys,
  input wire logic mod_clk_q,
  // level wanted, bitstream out
  input wire logic level,
  output logic mod_bit
);
  logic prev_q = 1'b0;
  logic bit_q = 1'b0;
  // new bit only on a modulator clock rise, as the real loop does
  always_ff @(posedge clk_sys) begin
    prev_q <= mod_clk_q;
    if (mod_clk_q && !prev_q) begin
      bit_q <= level;
    end
  end
  assign mod_bit = bit_q;
endmodule : mod_source
`default_nettype wire

// File: tick_divider.sv
// divides an enable tick by a fixed ratio, exposing the phase count
`timescale 1ns/10ps
`default_nettype none

module tick_divider #(
  parameter int unsigned DIV = 4,
  parameter int unsigned W = 2
) (
  // clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // tick in, divided tick and phase out
  input wire logic tick_in,
  output logic tick_q,
  output logic [W-1:0] phase_q
);

  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] phase_d;
  logic tick_d;

  always_comb begin
    phase_d = phase_q;
    tick_d = 1'b0;
    if (tick_in) begin
      if (phase_q == LAST) begin
        phase_d = '0;
        tick_d = 1'b1;
      end else begin
        phase_d = phase_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      phase_q <= phase_d;
      tick_q <= tick_d;
    end
  end

endmodule : tick_divider

`default_nettype wire
